//--- verilog/irq_control.sv
// interrupt control and status registers with cpu request logic
//
// How it works
// R01 - each source owns a flag; hardware sets it, software write clears it
// R02 - a source's request passes only while its enable bit is set
// R03 - each user source has a writable 3-bit priority, eight levels
// R04 - pending register latches 7-bit vector number and 4-bit level
// R05 - bit positions follow vector order; external 0 sits at bit 0
// R06 - cpu level is extension bit over the 3-bit status field
// R07 - field value 7 blocks every user interrupt; extension adds 8
// R08 - cpu priority field is writable except while nesting is disabled
// R09 - software can never set the extension bit
// R10 - nesting disable set means no interrupt nests into another
// R11 - control 1 holds overflow, address, stack, oscillator trap flags
// R12 - control 2 bit 15 selects the vector table
// R13 - control 2 bits 4..0 pick edge polarity, 1 falling, 0 rising
// R14 - flag register 0 maps converter down to external 0, bit 4 reserved
// R15 - unimplemented bits read zero and ignore writes
// R16 - table select set takes vectors from the alternate table
// R17 - request only when flag, enable set and priority above level
// R18 - deferral status bit reads 1 while a disable instruction runs
//
// The implementer's own choices: the address map and the Avalon-MM slave port.
`timescale 1ns/1ns
`default_nettype none
module irq_control
    import irq_ctl_pkg::*;
(
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic [5:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    input wire logic [NSRC-1:0] SRC_SET,
    input wire logic [NEXT-1:0] EXT_IRQ,
    input wire logic TRAP_ARITH,
    input wire logic TRAP_ADDR,
    input wire logic TRAP_STACK,
    input wire logic TRAP_OSC,
    input wire logic TRAP_TAKEN,
    input wire logic INT_ACK,
    input wire logic ISR_RETURN,
    input wire logic DEFER_ACTIVE,
    output logic INT_REQ,
    output logic [6:0] PEND_VECTOR,
    output logic [8:0] VECTOR_ADDR,
    output logic [3:0] CPU_LEVEL,
    output logic ALT_TABLE,
    output logic [NEXT-1:1] EXT_EDGE,
    output logic IRQ
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic ack_reg;
    logic [31:0] rdata_reg;
    logic [2:0] pri_field_reg;
    logic [2:0] saved_field_reg;
    logic ext_bit_reg;
    logic [15:0] gctrl1_reg;
    logic [15:0] gctrl2_reg;
    logic [15:0] flag_reg;
    logic [15:0] enable_reg;
    logic [15:0] prio_reg [4];
    logic [6:0] pend_vec_reg;
    logic [3:0] pend_lvl_reg;
    logic [8:0] vec_addr_reg;
    logic [2:0] evt_reg;
    logic [2:0] evt_mask_reg;
    logic [NEXT-1:0] ext_meta_reg;
    logic [NEXT-1:0] ext_sync_reg;
    logic [NEXT-1:0] ext_prev_reg;
    logic [NEXT-1:0] ext_edge_reg;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // byte-lane merge of a 16-bit register, unimplemented bits forced low
    function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wd,
                                          input logic [1:0] be, input logic [15:0] mask);
        merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]} & mask;
    endfunction : merge

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    // one wait state, then the access completes
    wire logic bus_req = AVS_READ | AVS_WRITE;
    wire logic wr_go = AVS_WRITE & ack_reg;
    wire logic [15:0] wd = AVS_WRITEDATA[15:0];
    wire logic [1:0] be = AVS_BYTEENABLE[1:0];
    wire logic wr_sr = wr_go && AVS_ADDRESS == OFF_STATUS_WORD;
    wire logic wr_core = wr_go && AVS_ADDRESS == OFF_CORE_CTRL;
    wire logic wr_g1 = wr_go && AVS_ADDRESS == OFF_GCTRL1;
    wire logic wr_g2 = wr_go && AVS_ADDRESS == OFF_GCTRL2;
    wire logic wr_flag = wr_go && AVS_ADDRESS == OFF_FLAG0;
    wire logic wr_en = wr_go && AVS_ADDRESS == OFF_ENABLE0;
    wire logic wr_evt = wr_go && AVS_ADDRESS == OFF_EVT_STATUS && be[0];
    wire logic wr_emask = wr_go && AVS_ADDRESS == OFF_EVT_MASK && be[0];
    wire logic [3:0] wr_prio = {wr_go && AVS_ADDRESS == OFF_PRIO3,
                                wr_go && AVS_ADDRESS == OFF_PRIO2,
                                wr_go && AVS_ADDRESS == OFF_PRIO1,
                                wr_go && AVS_ADDRESS == OFF_PRIO0};
    assign AVS_WAITREQUEST = bus_req & ~ack_reg;
    assign AVS_READDATA = rdata_reg;

    // ------------------------------------------------------------
    // arbitration
    // ------------------------------------------------------------
    logic [NSRC*PRI_W-1:0] prio_flat;
    logic arb_valid;
    logic [IDX_W-1:0] arb_idx;
    logic [PRI_W-1:0] arb_prio;
    // R05 bit order
    // source i takes priority slot i mod 4 of priority register i div 4
    always_comb begin
        prio_flat = '0;
        for (int i = 0; i < NSRC; i++) begin
            prio_flat[i*PRI_W +: PRI_W] = prio_reg[i/4][(i%4)*PRI_STRIDE +: PRI_W];
        end
    end

    // R06 level form
    wire logic [3:0] cpu_level = {ext_bit_reg, pri_field_reg};
    // R07 level block
    // field 7 or any extension level stays at or above every 3-bit priority
    irq_arbiter u_arb (
        .flags(flag_reg[NSRC-1:0]),
        .enables(enable_reg[NSRC-1:0]),
        .prios(prio_flat),
        .cpu_level(cpu_level),
        .req_valid(arb_valid),
        .win_idx(arb_idx),
        .win_prio(arb_prio)
    );
    // R17 cpu request
    assign INT_REQ = arb_valid;
    wire logic take = INT_ACK & arb_valid;
    wire logic [6:0] take_vec = 7'({3'h0, arb_idx}) + USER_VEC_BASE;

    // ------------------------------------------------------------
    // external pins and trap events
    // ------------------------------------------------------------
    // R13 edge polarity
    // falling edge when the polarity bit is 1, rising when 0
    wire logic [NEXT-1:0] pol = gctrl2_reg[NEXT-1:0];
    wire logic [NEXT-1:0] edge_now = (pol & ext_prev_reg & ~ext_sync_reg) |
                                     (~pol & ~ext_prev_reg & ext_sync_reg);
    assign EXT_EDGE = ext_edge_reg[NEXT-1:1];
    // R11 trap flags
    wire logic [15:0] trap_set = 16'(TRAP_ARITH) << G1_ARITH_BIT | 16'(TRAP_ADDR) << G1_ADDR_BIT |
                                 16'(TRAP_STACK) << G1_STACK_BIT | 16'(TRAP_OSC) << G1_OSC_BIT;
    // R14 flag map
    // external 0 rides on bit 0, bit 4 has no source
    wire logic [15:0] flag_set = {2'h0, SRC_SET | {{(NSRC-1){1'b0}}, ext_edge_reg[0]}} &
                                 FLAG0_MASK;
    wire logic [2:0] evt_set = {|ext_edge_reg, |trap_set, take};

    // ------------------------------------------------------------
    // next values
    // ------------------------------------------------------------
    // R01 flag update
    // hardware set wins over a clearing write in the same cycle
    wire logic [15:0] flag_next = (wr_flag ? merge(flag_reg, wd, be, FLAG0_MASK) : flag_reg) |
                                  flag_set;
    wire logic [15:0] g1_next = (wr_g1 ? merge(gctrl1_reg, wd, be, G1_MASK) : gctrl1_reg) |
                                trap_set;
    wire logic nest_dis = gctrl1_reg[G1_NEST_BIT];
    logic [2:0] pri_field_next;
    logic ext_bit_next;
    // R08 field write
    // R10 no nesting
    // a taken interrupt raises the field; with nesting off it goes to 7
    always_comb begin
        pri_field_next = pri_field_reg;
        if (take) begin
            pri_field_next = nest_dis ? PRI_FIELD_MAX : arb_prio;
        end else if (ISR_RETURN) begin
            pri_field_next = saved_field_reg;
        end else if (wr_sr && be[0] && !nest_dis) begin
            pri_field_next = wd[SR_PRI_LSB +: 3];
        end
    end
    // R09 extension bit
    // software may only clear it; trap entry sets it and wins
    always_comb begin
        ext_bit_next = ext_bit_reg;
        if (ISR_RETURN || (wr_core && be[0] && !wd[CORE_EXT_BIT])) begin
            ext_bit_next = 1'b0;
        end
        if (TRAP_TAKEN) begin
            ext_bit_next = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // readback
    // ------------------------------------------------------------
    // R15 zero fill
    logic [15:0] rd_word;
    always_comb begin
        unique case (AVS_ADDRESS)
            OFF_STATUS_WORD: rd_word = 16'({pri_field_reg, 5'h00});
            OFF_CORE_CTRL: rd_word = 16'({ext_bit_reg, 3'h0});
            OFF_GCTRL1: rd_word = gctrl1_reg;
            // R18 deferral status
            OFF_GCTRL2: rd_word = gctrl2_reg | (16'(DEFER_ACTIVE) << G2_DEFER_BIT);
            OFF_FLAG0: rd_word = flag_reg;
            OFF_ENABLE0: rd_word = enable_reg;
            OFF_PRIO0: rd_word = prio_reg[0];
            OFF_PRIO1: rd_word = prio_reg[1];
            OFF_PRIO2: rd_word = prio_reg[2];
            OFF_PRIO3: rd_word = prio_reg[3];
            // R04 pending layout
            OFF_PENDING: rd_word = {4'h0, pend_lvl_reg, 1'b0, pend_vec_reg};
            OFF_EVT_STATUS: rd_word = {13'h0000, evt_reg};
            OFF_EVT_MASK: rd_word = {13'h0000, evt_mask_reg};
            default: rd_word = 16'h0000;
        endcase
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // bus handshake and read data
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            ack_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= bus_req & ~ack_reg;
            rdata_reg <= AVS_READ ? {16'h0000, rd_word} : 32'h0000_0000;
        end
    end

    // cpu priority state
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            pri_field_reg <= 3'h0;
            saved_field_reg <= 3'h0;
            ext_bit_reg <= 1'b0;
        end else begin
            pri_field_reg <= pri_field_next;
            saved_field_reg <= take ? pri_field_reg : saved_field_reg;
            ext_bit_reg <= ext_bit_next;
        end
    end

    // R12 table select
    // R02 enables
    // R03 priority fields
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            gctrl1_reg <= REG_RESET;
            gctrl2_reg <= REG_RESET;
            flag_reg <= REG_RESET;
            enable_reg <= REG_RESET;
            for (int k = 0; k < 4; k++) begin
                prio_reg[k] <= REG_RESET;
            end
        end else begin
            gctrl1_reg <= g1_next;
            gctrl2_reg <= wr_g2 ? merge(gctrl2_reg, wd, be, G2_MASK) : gctrl2_reg;
            flag_reg <= flag_next;
            enable_reg <= wr_en ? merge(enable_reg, wd, be, FLAG0_MASK) : enable_reg;
            for (int k = 0; k < 4; k++) begin
                if (wr_prio[k]) begin
                    prio_reg[k] <= merge(prio_reg[k], wd, be, k == 3 ? PRIO3_MASK : PRIO_MASK);
                end
            end
        end
    end

    // R04 vector latch
    // R16 alternate table
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            pend_vec_reg <= 7'h00;
            pend_lvl_reg <= 4'h0;
            vec_addr_reg <= 9'h000;
        end else if (take) begin
            pend_vec_reg <= take_vec;
            pend_lvl_reg <= {1'b0, arb_prio};
            vec_addr_reg <= (gctrl2_reg[G2_TABLE_BIT] ? ALT_TABLE_BASE : DEFAULT_TABLE_BASE) +
                            {1'b0, take_vec, 1'b0};
        end
    end

    // pin synchronisers and edge capture
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            ext_meta_reg <= '0;
            ext_sync_reg <= '0;
            ext_prev_reg <= '0;
            ext_edge_reg <= '0;
        end else begin
            ext_meta_reg <= EXT_IRQ;
            ext_sync_reg <= ext_meta_reg;
            ext_prev_reg <= ext_sync_reg;
            ext_edge_reg <= edge_now;
        end
    end

    // event status, write one to clear, set wins
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            evt_reg <= 3'h0;
            evt_mask_reg <= 3'h0;
        end else begin
            evt_reg <= ((wr_evt ? evt_reg & ~wd[2:0] : evt_reg) | evt_set) & EVT_MASK;
            evt_mask_reg <= wr_emask ? wd[2:0] : evt_mask_reg;
        end
    end

    assign IRQ = |(evt_reg & evt_mask_reg);
    assign PEND_VECTOR = pend_vec_reg;
    assign VECTOR_ADDR = vec_addr_reg;
    assign CPU_LEVEL = cpu_level;
    assign ALT_TABLE = gctrl2_reg[G2_TABLE_BIT];

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);

    sequence s_take;
        INT_ACK && INT_REQ;
    endsequence
    sequence s_rise0;
        !ext_sync_reg[0] ##1 (ext_sync_reg[0] && !pol[0]);
    endsequence

    chk_flag_set: assert property ( // R01
        1'b1 |=> ((flag_reg & $past(flag_set)) == $past(flag_set)))
        else $error("flag set lost");
    chk_flag_hold: assert property ( // R01
        !wr_flag |=> (($past(flag_reg) & ~flag_reg) == 16'h0000))
        else $error("flag cleared without write");
    chk_req_gate: assert property ( // R17
        INT_REQ |-> (flag_reg[arb_idx] && enable_reg[arb_idx] && {1'b0, arb_prio} > cpu_level))
        else $error("request without cause");
    chk_level_block: assert property ( // R07
        (pri_field_reg == 3'h7 || ext_bit_reg) |-> !INT_REQ)
        else $error("request at blocked level");
    chk_field_locked: assert property ( // R08
        (wr_sr && nest_dis && !take && !ISR_RETURN) |=> $stable(pri_field_reg))
        else $error("field written while locked");
    chk_ext_no_set: assert property ( // R09
        (!ext_bit_reg && !TRAP_TAKEN) |=> !ext_bit_reg)
        else $error("extension bit set without trap");
    chk_pend_latch: assert property ( // R04
        s_take |=> (pend_vec_reg == $past(take_vec) && pend_lvl_reg == {1'b0, $past(arb_prio)}))
        else $error("pending vector wrong");
    chk_nest_raise: assert property ( // R10
        (s_take ##0 nest_dis && !ISR_RETURN) |=> pri_field_reg == 3'h7)
        else $error("nesting not blocked");
    chk_trap_flag: assert property ( // R11
        TRAP_ARITH |=> gctrl1_reg[G1_ARITH_BIT])
        else $error("arith trap flag missing");
    chk_alt_addr: assert property ( // R16
        (s_take ##0 ALT_TABLE) |=> VECTOR_ADDR == ALT_TABLE_BASE + {1'b0, pend_vec_reg, 1'b0})
        else $error("alternate vector address wrong");
    chk_edge_flag: assert property ( // R13
        s_rise0 |-> ##2 flag_reg[0])
        else $error("rising edge not flagged");
    chk_bus_wait: assert property (
        (bus_req && !ack_reg) |-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST)
        else $error("bus answer not one wait");
endmodule : irq_control
`default_nettype wire

//--- verilog/irq_ctl_pkg.sv
// constants for the interrupt control and status block
package irq_ctl_pkg;
    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int NSRC = 14;
    localparam int NEXT = 5;
    localparam int PRI_W = 3;
    localparam int IDX_W = 4;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [5:0] OFF_STATUS_WORD = 6'h00;
    localparam logic [5:0] OFF_CORE_CTRL = 6'h04;
    localparam logic [5:0] OFF_GCTRL1 = 6'h08;
    localparam logic [5:0] OFF_GCTRL2 = 6'h0c;
    localparam logic [5:0] OFF_FLAG0 = 6'h10;
    localparam logic [5:0] OFF_ENABLE0 = 6'h14;
    localparam logic [5:0] OFF_PRIO0 = 6'h18;
    localparam logic [5:0] OFF_PRIO1 = 6'h1c;
    localparam logic [5:0] OFF_PRIO2 = 6'h20;
    localparam logic [5:0] OFF_PRIO3 = 6'h24;
    localparam logic [5:0] OFF_PENDING = 6'h28;
    localparam logic [5:0] OFF_EVT_STATUS = 6'h2c;
    localparam logic [5:0] OFF_EVT_MASK = 6'h30;

    // ------------------------------------------------------------
    // field positions and masks
    // ------------------------------------------------------------
    localparam int SR_PRI_LSB = 5;
    localparam int CORE_EXT_BIT = 3;
    localparam int G1_NEST_BIT = 15;
    localparam int G1_ARITH_BIT = 4;
    localparam int G1_ADDR_BIT = 3;
    localparam int G1_STACK_BIT = 2;
    localparam int G1_OSC_BIT = 1;
    localparam int G2_TABLE_BIT = 15;
    localparam int G2_DEFER_BIT = 14;
    localparam int PEND_LVL_LSB = 8;
    localparam int PRI_STRIDE = 4;
    localparam int RSVD_SRC = 4;
    localparam logic [15:0] FLAG0_MASK = 16'h3fef;
    localparam logic [15:0] PRIO_MASK = 16'h7777;
    localparam logic [15:0] PRIO3_MASK = 16'h0077;
    localparam logic [15:0] G1_MASK = 16'h801e;
    localparam logic [15:0] G2_MASK = 16'h801f;
    localparam logic [2:0] EVT_MASK = 3'h7;
    localparam int EVT_VECTOR = 0;
    localparam int EVT_TRAP = 1;
    localparam int EVT_EDGE = 2;

    // ------------------------------------------------------------
    // reset values and vector constants
    // ------------------------------------------------------------
    localparam logic [15:0] REG_RESET = 16'h0000;
    localparam logic [2:0] PRI_FIELD_MAX = 3'h7;
    localparam logic [6:0] USER_VEC_BASE = 7'h08;
    localparam logic [8:0] DEFAULT_TABLE_BASE = 9'h004;
    localparam logic [8:0] ALT_TABLE_BASE = 9'h104;
endpackage : irq_ctl_pkg

//--- verilog/irq_arbiter.sv
// winner search among pending, enabled sources
`timescale 1ns/1ns
`default_nettype none
module irq_arbiter
    import irq_ctl_pkg::*;
(
    input wire logic [NSRC-1:0] flags,
    input wire logic [NSRC-1:0] enables,
    input wire logic [NSRC*PRI_W-1:0] prios,
    input wire logic [3:0] cpu_level,
    output logic req_valid,
    output logic [IDX_W-1:0] win_idx,
    output logic [PRI_W-1:0] win_prio
);
    // ------------------------------------------------------------
    // search
    // ------------------------------------------------------------
    // a source beats the level only with a strictly higher priority
    function automatic logic beats(input logic [PRI_W-1:0] p, input logic [3:0] lvl);
        beats = {1'b0, p} > lvl;
    endfunction : beats

    // scan down so that an equal priority at a lower index wins
    always_comb begin
        req_valid = 1'b0;
        win_idx = '0;
        win_prio = '0;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (flags[i] && enables[i] && beats(prios[i*PRI_W +: PRI_W], cpu_level) &&
                (!req_valid || prios[i*PRI_W +: PRI_W] >= win_prio)) begin
                req_valid = 1'b1;
                win_idx = IDX_W'(i);
                win_prio = prios[i*PRI_W +: PRI_W];
            end
        end
    end
endmodule : irq_arbiter
`default_nettype wire

//--- sim/cpu_partner.sv
// cpu side model that takes interrupt requests after a set delay
`timescale 1ns/1ns
`default_nettype none
module cpu_partner (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic ACK_EN,
    input wire logic [3:0] ACK_DELAY,
    input wire logic INT_REQ,
    output logic INT_ACK
);
    logic [3:0] wait_reg;
    // --------------------------------------------------------
    // acknowledge
    // --------------------------------------------------------
    // count the delay while a request stands, then pulse ack once
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            wait_reg <= 4'h0;
            INT_ACK <= 1'b0;
        end else begin
            INT_ACK <= 1'b0;
            if (ACK_EN && INT_REQ && !INT_ACK) begin
                if (wait_reg >= ACK_DELAY) begin
                    INT_ACK <= 1'b1;
                    wait_reg <= 4'h0;
                end else begin
                    wait_reg <= wait_reg + 4'h1;
                end
            end else begin
                wait_reg <= 4'h0;
            end
        end
    end
endmodule : cpu_partner
`default_nettype wire

//--- sim/tb_top.sv
// self-checking bench for the interrupt control block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import irq_ctl_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [5:0] addr = 6'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = 32'h00000000;
    logic [NSRC-1:0] src_set = 14'h0000;
    logic [NEXT-1:0] ext_irq = 5'h00;
    logic [3:0] traps = 4'h0;
    logic trap_taken = 1'b0;
    logic defer = 1'b0;
    logic isr_ret = 1'b0;
    logic ack_en = 1'b0;
    logic [31:0] rdata;
    logic waitreq;
    logic int_ack;
    logic int_req;
    logic alt_table;
    logic irq;
    logic [NEXT-1:1] ext_edge;
    int pulses = 0;
    logic [6:0] pend_vec;
    logic [8:0] vec_addr;
    logic [3:0] cpu_level;
    int bad_count = 0;
    int check_count = 0;
    logic [31:0] got;

    initial begin
        forever #5 clk = ~clk;
    end

    irq_control u_irq_control (.CLK(clk), .RST_B(rst_b), .AVS_ADDRESS(addr), .AVS_READ(rd),
        .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'hf), .AVS_READDATA(rdata),
        .AVS_WAITREQUEST(waitreq), .SRC_SET(src_set), .EXT_IRQ(ext_irq),
        .TRAP_ARITH(traps[3]), .TRAP_ADDR(traps[2]), .TRAP_STACK(traps[1]),
        .TRAP_OSC(traps[0]), .TRAP_TAKEN(trap_taken), .INT_ACK(int_ack), .ISR_RETURN(isr_ret),
        .DEFER_ACTIVE(defer), .INT_REQ(int_req), .PEND_VECTOR(pend_vec),
        .VECTOR_ADDR(vec_addr), .CPU_LEVEL(cpu_level), .ALT_TABLE(alt_table),
        .EXT_EDGE(ext_edge), .IRQ(irq));
    cpu_partner u_cpu_partner (.CLK(clk), .RST_B(rst_b), .ACK_EN(ack_en), .ACK_DELAY(4'h2),
        .INT_REQ(int_req), .INT_ACK(int_ack));

    // --------------------------------------------------------
    // tasks
    // --------------------------------------------------------
    task automatic results;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : results

    task automatic cmp(input logic [31:0] g, input logic [31:0] e, input string what);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected at %0t: %s got %h exp %h", $time, what, g, e);
        end
    endtask : cmp

    // one avalon access, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [5:0] a, input logic [15:0] d);
        int n;
        @(posedge clk);
        addr <= a;
        rd <= !w;
        wr <= w;
        wdata <= {16'h0000, d};
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (waitreq !== 1'b0 && n < 20);
        got = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        if (n >= 20) begin
            bad_count++;
            results();
        end
    endtask : bus

    task automatic rchk(input logic [5:0] a, input logic [15:0] e);
        bus(1'b0, a, 16'h0000);
        cmp(got, {16'h0000, e}, $sformatf("register %h", a));
    endtask : rchk

    task automatic pulse_src(input logic [NSRC-1:0] m);
        @(posedge clk);
        src_set <= m;
        @(posedge clk);
        src_set <= 14'h0000;
        @(posedge clk);
    endtask : pulse_src

    // wait for the cpu model to take a request, then look after the edge
    task automatic wait_ack(input logic [6:0] v, input logic [8:0] va, input logic [3:0] lv);
        int n;
        n = 0;
        ack_en <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (int_ack !== 1'b1 && n < 40);
        if (n >= 40) begin
            bad_count++;
            results();
        end
        ack_en <= 1'b0;
        @(posedge clk);
        cmp(32'(pend_vec), 32'(v), "vector");
        cmp(32'(vec_addr), 32'(va), "vector address");
        cmp(32'(cpu_level), 32'(lv), "cpu level");
    endtask : wait_ack

    // --------------------------------------------------------
    // main sequence
    // --------------------------------------------------------
    initial begin
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 13; i++) rchk(6'(i * 4), 16'h0000);
        bus(1'b1, 6'h34, 16'hffff);
        rchk(6'h34, 16'h0000);
        bus(1'b1, OFF_FLAG0, 16'hffff);
        rchk(OFF_FLAG0, 16'h3fef);
        bus(1'b1, OFF_FLAG0, 16'h0000);
        pulse_src(14'h3fff);
        rchk(OFF_FLAG0, 16'h3fef);
        bus(1'b1, OFF_FLAG0, 16'h0000);
        bus(1'b1, OFF_PRIO3, 16'hffff);
        rchk(OFF_PRIO3, 16'h0077);
        bus(1'b1, OFF_GCTRL2, 16'hffff);
        rchk(OFF_GCTRL2, 16'h801f);
        cmp(32'(alt_table), 32'h1, "table select");
        defer <= 1'b1;
        bus(1'b1, OFF_GCTRL2, 16'h0000);
        rchk(OFF_GCTRL2, 16'h4000);
        defer <= 1'b0;
        // two equal priorities pending: lower vector wins
        bus(1'b1, OFF_PRIO0, 16'h5000);
        bus(1'b1, OFF_PRIO1, 16'h0050);
        pulse_src(14'h0028);
        cmp(32'(int_req), 32'h0, "request while disabled");
        bus(1'b1, OFF_ENABLE0, 16'h0029);
        @(posedge clk);
        cmp(32'(int_req), 32'h1, "request");
        wait_ack(7'h0b, 9'h01a, 4'h5);
        rchk(OFF_PENDING, 16'h050b);
        cmp(32'(int_req), 32'h0, "equal level");
        bus(1'b1, OFF_PRIO1, 16'h0060);
        bus(1'b1, OFF_GCTRL2, 16'h8000);
        wait_ack(7'h0d, 9'h11e, 4'h6);
        // field 7 blocks a priority 7 source
        bus(1'b1, OFF_STATUS_WORD, 16'h00e0);
        bus(1'b1, OFF_PRIO0, 16'h5007);
        pulse_src(14'h0001);
        cmp(32'(int_req), 32'h0, "level 7 block");
        bus(1'b1, OFF_GCTRL1, 16'h8000);
        bus(1'b1, OFF_STATUS_WORD, 16'h0020);
        rchk(OFF_STATUS_WORD, 16'h00e0);
        bus(1'b1, OFF_GCTRL1, 16'h0000);
        bus(1'b1, OFF_STATUS_WORD, 16'h0020);
        rchk(OFF_STATUS_WORD, 16'h0020);
        bus(1'b1, OFF_GCTRL1, 16'h8000);
        wait_ack(7'h08, 9'h114, 4'h7);
        // extension bit set by a trap only
        @(posedge clk);
        trap_taken <= 1'b1;
        @(posedge clk);
        trap_taken <= 1'b0;
        rchk(OFF_CORE_CTRL, 16'h0008);
        cmp(32'(cpu_level), 32'hf, "extended level");
        bus(1'b1, OFF_CORE_CTRL, 16'h0000);
        bus(1'b1, OFF_CORE_CTRL, 16'h0008);
        rchk(OFF_CORE_CTRL, 16'h0000);
        // a return restores the field saved when the last vector was taken
        @(posedge clk);
        isr_ret <= 1'b1;
        @(posedge clk);
        isr_ret <= 1'b0;
        @(posedge clk);
        cmp(32'(cpu_level), 32'h1, "level after return");
        // trap flags and the event interrupt
        bus(1'b1, OFF_EVT_STATUS, 16'h0007);
        @(posedge clk);
        traps <= 4'hf;
        @(posedge clk);
        traps <= 4'h0;
        rchk(OFF_GCTRL1, 16'h801e);
        cmp(32'(irq), 32'h0, "masked event");
        bus(1'b1, OFF_EVT_MASK, 16'h0002);
        @(posedge clk);
        cmp(32'(irq), 32'h1, "unmasked event");
        bus(1'b1, OFF_EVT_STATUS, 16'h0002);
        @(posedge clk);
        cmp(32'(irq), 32'h0, "event cleared");
        // falling edge polarity on external pin 0
        bus(1'b1, OFF_GCTRL2, 16'h0001);
        bus(1'b1, OFF_FLAG0, 16'h0000);
        ext_irq <= 5'h01;
        repeat (6) @(posedge clk);
        rchk(OFF_FLAG0, 16'h0000);
        ext_irq <= 5'h00;
        repeat (6) @(posedge clk);
        rchk(OFF_FLAG0, 16'h0001);
        // rising edge polarity on pins 0 and 1, with the edge pulse output
        bus(1'b1, OFF_GCTRL2, 16'h0000);
        bus(1'b1, OFF_FLAG0, 16'h0000);
        ext_irq <= 5'h03;
        repeat (6) begin
            @(posedge clk);
            if (ext_edge === 4'h1) begin
                pulses++;
            end
        end
        cmp(32'(pulses), 32'h1, "edge pulse");
        rchk(OFF_FLAG0, 16'h0001);
        results();
    end

    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        results();
    end
endmodule : tb_top
`default_nettype wire
